// >>> hw/storage_access_channel.sv
`include "storage_access_consts.svh"

// Overview of operation
// - Sixteen shared data lines, both directions
// - Write word driven active high
// - Parity line gives odd parity over eighteen
// - Controller drives sixteen address lines
// - Request held until resume arrives
// - Resume clears request and address
// - Fault lines sampled at resume
// - Direction low reads, high writes memory
// - Override low permits protected writes
// - System clear low resets controller
// - Priority hold low locks out CPU
// - Four ring scanner connections provided
// - Halt scanner and request together
module storage_access_channel #(
   parameter bit FIRST_STAGE = 1'b0,   // First ring stage inverts forward scan
   parameter int BUF_DEPTH   = 2
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   // User command side
   input  wire logic                      cmd_valid,
   output logic                           cmd_ready,
   input  wire storage_access_pkg::cmd_t  cmd,
   // User result side
   output logic                           res_valid,
   input  wire logic                      res_ready,
   output storage_access_pkg::result_t    res,
   // User levels
   input  wire logic                      priority_request,
   output logic                           boot_load_seen,
   output logic                           two_bank_mode,
   output logic                           channel_cleared,
   // Channel pins
   input  wire logic [15:0]               mem_data_in,
   output logic [15:0]                    mem_data_out,
   output logic                           mem_data_oe,
   input  wire logic                      parity_in,
   output logic                           parity_out,
   output logic                           parity_oe,
   input  wire logic                      protect_state_line,
   input  wire logic                      parity_error_line_n,
   input  wire logic                      protect_violation_n,
   output logic [15:0]                    mem_address_lines,
   output logic                           mem_request_n,
   input  wire logic                      mem_resume_n,
   output logic                           transfer_direction,
   output logic                           protect_override_n,
   output logic                           priority_hold_n,
   input  wire logic                      system_clear_n,
   input  wire logic                      boot_load_strobe_n,
   input  wire logic                      bank_mode_n,
   input  wire logic                      ring_forward_in,
   input  wire logic                      ring_reverse_in,
   output logic                           ring_forward_out,
   output logic                           ring_reverse_out
);

   localparam int SYNC_W = 26;
   localparam logic [7:0] SETTLE_LAST = 8'(`READ_SETTLE_CYC - 1);

   storage_access_pkg::state_t  state_q;
   storage_access_pkg::cmd_t    cmd_q;
   storage_access_pkg::result_t res_q;

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic [SYNC_W-1:0] raw_in;

   logic [15:0] data_s;
   logic        parity_s;
   logic        protect_s;
   logic        perr_n_s;
   logic        pviol_n_s;
   logic        resume_n_s;
   logic        clear_n_s;
   logic        boot_n_s;
   logic        bank_n_s;
   logic        fwd_in_s;
   logic        rev_in_s;

   logic        clr;
   logic        halt;
   logic        stage_q;
   logic [7:0]  cnt_q;
   logic        cmd_ready_q;
   logic        push_q;
   logic        buf_ready;
   logic        buf_valid;
   logic [$bits(storage_access_pkg::result_t)-1:0] buf_data;

   logic [15:0] data_out_q;
   logic        data_oe_q;
   logic        parity_out_q;
   logic        parity_oe_q;
   logic [15:0] addr_q;
   logic        request_n_q;
   logic        direction_q;
   logic        override_n_q;
   logic        hold_n_q;
   logic        fwd_out_q;
   logic        rev_out_q;
   logic        boot_q;
   logic        bank_q;
   logic        cleared_q;

   // All channel inputs are asynchronous to clk
   assign raw_in = {mem_data_in, parity_in, protect_state_line, parity_error_line_n,
                    protect_violation_n, mem_resume_n, system_clear_n,
                    boot_load_strobe_n, bank_mode_n, ring_forward_in, ring_reverse_in};

   // Two-flop synchroniser; reset to idle levels, never by system clear
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= `SYNC_RESET;
         sync_q <= `SYNC_RESET;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end

   assign data_s     = sync_q[25:10];
   assign parity_s   = sync_q[9];
   assign protect_s  = sync_q[8];
   assign perr_n_s   = sync_q[7];
   assign pviol_n_s  = sync_q[6];
   assign resume_n_s = sync_q[5];
   assign clear_n_s  = sync_q[4];
   assign boot_n_s   = sync_q[3];
   assign bank_n_s   = sync_q[2];
   assign fwd_in_s   = sync_q[1];
   assign rev_in_s   = sync_q[0];

   // Local reset or system clear from the computer
   assign clr = reset | ~clear_n_s;

   // Scanner stops here while our request is outstanding
   assign halt = ((state_q == storage_access_pkg::ST_ARB) && stage_q) ||
                 (state_q == storage_access_pkg::ST_REQ);

   // Ring stage: follows forward scan unless halted
   always_ff @(posedge clk) begin
      if (clr) begin
         stage_q   <= 1'b0;
         fwd_out_q <= 1'b0;
         rev_out_q <= 1'b0;
      end else begin
         stage_q   <= halt ? stage_q : fwd_in_s;
         fwd_out_q <= stage_q ^ FIRST_STAGE;
         rev_out_q <= halt ? rev_out_q : rev_in_s;
      end
   end

   // Status levels for the user side, and the priority hold pin
   always_ff @(posedge clk) begin
      if (reset) begin
         boot_q    <= 1'b0;
         bank_q    <= 1'b0;
         cleared_q <= 1'b0;
         hold_n_q  <= 1'b1;
      end else begin
         boot_q    <= ~boot_n_s;
         bank_q    <= ~bank_n_s;
         cleared_q <= ~clear_n_s;
         hold_n_q  <= clear_n_s ? ~priority_request : 1'b1;
      end
   end

   // Sequencer for one storage cycle
   always_ff @(posedge clk) begin
      if (clr) begin
         state_q     <= storage_access_pkg::ST_IDLE;
         cmd_q       <= '0;
         res_q       <= '0;
         cnt_q       <= 8'h00;
         cmd_ready_q <= 1'b0;
         push_q      <= 1'b0;
      end else begin
         case (state_q)
            storage_access_pkg::ST_IDLE: begin
               cmd_ready_q <= 1'b1;
               if (cmd_valid && cmd_ready_q) begin
                  cmd_q       <= cmd;
                  cmd_ready_q <= 1'b0;
                  state_q     <= storage_access_pkg::ST_ARB;
               end
            end
            storage_access_pkg::ST_ARB: begin
               // Wait for the scan to reach our stage
               if (stage_q) begin
                  state_q <= storage_access_pkg::ST_REQ;
               end
            end
            storage_access_pkg::ST_REQ: begin
               // No timeout: refresh and CPU cycles stretch this wait
               if (!resume_n_s) begin
                  res_q.to_mem        <= cmd_q.to_mem;
                  res_q.parity_error  <= ~perr_n_s;
                  res_q.protect_fault <= ~pviol_n_s;
                  res_q.data          <= `DATA_RESET;
                  res_q.parity_bad    <= 1'b0;
                  cnt_q               <= 8'h00;
                  state_q             <= storage_access_pkg::ST_SETTLE;
               end
            end
            storage_access_pkg::ST_SETTLE: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == SETTLE_LAST) begin
                  if (!cmd_q.to_mem) begin
                     res_q.data       <= ~data_s;
                     // Raw high count over all eighteen lines must be odd
                     res_q.parity_bad <= ~(^{data_s, protect_s, parity_s});
                  end
                  state_q <= storage_access_pkg::ST_RELEASE;
               end
            end
            storage_access_pkg::ST_RELEASE: begin
               if (resume_n_s) begin
                  push_q  <= 1'b1;
                  state_q <= storage_access_pkg::ST_PUSH;
               end
            end
            storage_access_pkg::ST_PUSH: begin
               // A full buffer stalls the next command here
               if (buf_ready) begin
                  push_q  <= 1'b0;
                  state_q <= storage_access_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= storage_access_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Request, address, direction and override pins
   always_ff @(posedge clk) begin
      if (clr) begin
         addr_q       <= `ADDR_RESET;
         request_n_q  <= 1'b1;
         direction_q  <= 1'b0;
         override_n_q <= 1'b1;
      end else if ((state_q == storage_access_pkg::ST_ARB) && stage_q) begin
         addr_q       <= cmd_q.addr;
         request_n_q  <= 1'b0;
         direction_q  <= cmd_q.to_mem;
         override_n_q <= ~cmd_q.override;
      end else if ((state_q == storage_access_pkg::ST_REQ) && !resume_n_s) begin
         addr_q      <= `ADDR_RESET;
         request_n_q <= 1'b1;
      end else if (state_q == storage_access_pkg::ST_IDLE) begin
         direction_q  <= 1'b0;
         override_n_q <= 1'b1;
      end
   end

   // Data and parity drive; held steady through the settle wait
   always_ff @(posedge clk) begin
      if (clr) begin
         data_out_q   <= `DATA_RESET;
         data_oe_q    <= 1'b0;
         parity_out_q <= 1'b0;
         parity_oe_q  <= 1'b0;
      end else if ((state_q == storage_access_pkg::ST_ARB) && stage_q && cmd_q.to_mem) begin
         data_out_q   <= cmd_q.data;
         data_oe_q    <= 1'b1;
         // Protect state of the new location unknown yet; idle level assumed
         parity_out_q <= ~(^{cmd_q.data, protect_s});
         parity_oe_q  <= 1'b1;
      end else if ((state_q == storage_access_pkg::ST_SETTLE) && (cnt_q == SETTLE_LAST)) begin
         data_oe_q   <= 1'b0;
         parity_oe_q <= 1'b0;
      end else if (data_oe_q) begin
         // Restate parity once the addressed word's protect state has arrived
         parity_out_q <= ~(^{data_out_q, protect_s});
      end
   end

   result_buffer #(
      .WIDTH ($bits(storage_access_pkg::result_t)),
      .DEPTH (BUF_DEPTH)
   ) u_result_buffer (
      .clk       (clk),
      .clear     (clr),
      .in_valid  (push_q),
      .in_ready  (buf_ready),
      .in_data   (res_q),
      .out_valid (buf_valid),
      .out_ready (res_ready),
      .out_data  (buf_data)
   );

   // Outputs, each a flop or a buffer flop
   assign cmd_ready          = cmd_ready_q;
   assign res_valid          = buf_valid;
   assign res                = storage_access_pkg::result_t'(buf_data);
   assign boot_load_seen     = boot_q;
   assign two_bank_mode      = bank_q;
   assign channel_cleared    = cleared_q;
   assign mem_data_out       = data_out_q;
   assign mem_data_oe        = data_oe_q;
   assign parity_out         = parity_out_q;
   assign parity_oe          = parity_oe_q;
   assign mem_address_lines  = addr_q;
   assign mem_request_n      = request_n_q;
   assign transfer_direction = direction_q;
   assign protect_override_n = override_n_q;
   assign priority_hold_n    = hold_n_q;
   assign ring_forward_out   = fwd_out_q;
   assign ring_reverse_out   = rev_out_q;

endmodule

// >>> hw/storage_access_consts.svh
`ifndef STORAGE_ACCESS_CONSTS_SVH
`define STORAGE_ACCESS_CONSTS_SVH

// Clock rate of the controller logic
`define CLK_MHZ            100

// Lines on the channel
`define DATA_LINES         16
`define ADDR_LINES         16

// Wait after resume before read data is taken off the lines
`define READ_SETTLE_NS     120
`define READ_SETTLE_CYC    ((`READ_SETTLE_NS * `CLK_MHZ + 999) / 1000)

// Idle levels of the synchronised inputs, see sync vector layout
`define SYNC_RESET         26'h00001FC

// Idle levels of the driven pins
`define ADDR_RESET         16'h0000
`define DATA_RESET         16'h0000

`endif

// >>> hw/storage_access_pkg.sv
package storage_access_pkg;

   // One transfer asked for by the user side
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;      // Word to store, ignored on reads
      logic        to_mem;    // 1: controller to memory, 0: memory to controller
      logic        override;  // 1: may write protected locations
   } cmd_t;

   // Outcome of one storage cycle
   typedef struct packed {
      logic [15:0] data;          // Word read, zero on writes
      logic        to_mem;
      logic        parity_error;  // Parity error line low at resume
      logic        protect_fault; // Protect violation line low at resume
      logic        parity_bad;    // Local odd-parity check failed on a read
   } result_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARB,
      ST_REQ,
      ST_SETTLE,
      ST_RELEASE,
      ST_PUSH
   } state_t;

endpackage

// >>> hw/result_buffer.sv
// Shift-style buffer: entry 0 is always the head, so the read side sees flops only
module result_buffer #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             clear,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   logic [WIDTH-1:0] data_q [DEPTH];
   logic [DEPTH-1:0] valid_q;
   logic [DEPTH:0]   valid_ext;
   logic [WIDTH-1:0] data_ext [DEPTH+1];
   logic [DEPTH-1:0] shift_v;
   logic [DEPTH:0]   below_v;
   logic [WIDTH-1:0] shift_d [DEPTH];
   logic             pop;
   logic             push;

   // No push while full, even if popping: keeps in_ready off the read path
   assign in_ready  = ~valid_q[DEPTH-1];
   assign out_valid = valid_q[0];
   assign out_data  = data_q[0];
   assign pop       = valid_q[0] & out_ready;
   assign push      = in_valid & in_ready;
   assign valid_ext = {1'b0, valid_q};
   assign below_v   = {shift_v, 1'b1};
   assign data_ext[DEPTH] = '0;

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_entry
         logic take;

         assign data_ext[i] = data_q[i];
         assign shift_v[i]  = pop ? valid_ext[i+1] : valid_q[i];
         assign shift_d[i]  = pop ? data_ext[i+1] : data_q[i];
         // New word lands in the first free slot after the shift
         assign take        = push & ~shift_v[i] & below_v[i];

         always_ff @(posedge clk) begin
            if (clear) begin
               valid_q[i] <= 1'b0;
            end else begin
               valid_q[i] <= shift_v[i] | take;
            end
         end

         always_ff @(posedge clk) begin
            data_q[i] <= take ? in_data : shift_d[i];
         end
      end
   endgenerate

endmodule

// >>> testbench/storage_access_channel_asserts.sv
module storage_access_channel_asserts #(
   parameter int BUF_DEPTH = 2
) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [15:0] mem_data_out,
   input wire logic        mem_data_oe,
   input wire logic        parity_out,
   input wire logic        protect_state_line,
   input wire logic [15:0] mem_address_lines,
   input wire logic        mem_request_n,
   input wire logic        mem_resume_n,
   input wire logic        transfer_direction,
   input wire logic        priority_request,
   input wire logic        priority_hold_n,
   input wire logic        system_clear_n,
   input wire logic        channel_cleared
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Clear neither pending nor in force; the clear path may drop anything
   wire live = system_clear_n && !channel_cleared;
   sequence s_resume_seen;
      live && !mem_request_n && !mem_resume_n;
   endsequence
   sequence s_request_gone;
      mem_request_n && mem_address_lines == 16'h0000;
   endsequence
   sequence s_cleared;
      channel_cleared ##1 (mem_request_n && !mem_data_oe);
   endsequence
   AST_REQ_HELD: assert property (live && !mem_request_n && mem_resume_n |=> !mem_request_n)
      else $error("request dropped early");
   AST_RESUME_ENDS: assert property (s_resume_seen |-> ##[1:4] s_request_gone)
      else $error("request not ended by resume");
   AST_ADDR_ZERO: assert property ($rose(mem_request_n) |-> mem_address_lines == 16'h0000)
      else $error("address kept after request");
   AST_ADDR_STABLE: assert property (!mem_request_n && !$past(mem_request_n) |->
      $stable(mem_address_lines) && $stable(transfer_direction))
      else $error("address or direction moved");
   AST_WRITE_DRIVES: assert property (!mem_request_n && transfer_direction |-> mem_data_oe)
      else $error("write word not driven");
   AST_READ_FLOATS: assert property (!transfer_direction |-> !mem_data_oe)
      else $error("data driven on read");
   AST_PARITY_ODD: assert property (mem_data_oe && $past(mem_data_oe, 6) |->
      ^{mem_data_out, protect_state_line, parity_out})
      else $error("parity not odd");
   AST_HOLD: assert property (live && priority_request |-> ##[1:3] !priority_hold_n)
      else $error("hold not asserted");
   AST_CLEAR: assert property ($fell(system_clear_n) |-> ##[1:4] s_cleared)
      else $error("clear ignored");
endmodule

bind storage_access_channel storage_access_channel_asserts #(.BUF_DEPTH(BUF_DEPTH))
   i_storage_access_channel_asserts (
   .clk, .reset, .mem_data_out, .mem_data_oe, .parity_out, .protect_state_line,
   .mem_address_lines, .mem_request_n, .mem_resume_n, .transfer_direction,
   .priority_request, .priority_hold_n, .system_clear_n, .channel_cleared
);

// >>> testbench/storage_host_model.sv
module storage_host_model #(
   parameter logic [15:0] PROT_ADDR = 16'h8003
) (
   input  wire logic        clk,
   input  wire logic        mem_request_n,
   input  wire logic [15:0] mem_address_lines,
   input  wire logic        transfer_direction,
   input  wire logic        protect_override_n,
   input  wire logic        priority_hold_n,
   input  wire logic [15:0] bus,
   input  wire logic        perr,
   input  wire logic        bad_par,
   input  wire logic        prot_sw,
   input  wire logic        slow,
   output logic             mem_resume_n,
   output logic [15:0]      host_data,
   output logic             host_par,
   output logic             protect_state_line,
   output logic             parity_error_line_n,
   output logic             protect_violation_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:31];
   logic [15:0] a;
   logic [4:0]  ix;
   int          w;
   int          tick = 0;
   // Free count marks the refresh slots
   always @(posedge clk) tick <= tick + 1;
   // One storage cycle per request
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
      mem_resume_n = 1'b1;
      host_data = 16'h0000;
      host_par = 1'b1;
      protect_state_line = 1'b1;
      parity_error_line_n = 1'b1;
      protect_violation_n = 1'b1;
      forever begin
         @(posedge clk);
         if (!mem_request_n) begin
            a = mem_address_lines;
            ix = {a[15], a[3:0]};
            protect_state_line <= (a != PROT_ADDR);
            // CPU steals slots unless held off or in the other bank
            w = 2 + ((!a[15] && priority_hold_n) ? 4 : 0);
            w = w + ((tick % 64 < 8) ? 3 : 0);
            w = slow ? w + 40 : w;
            while (w > 0 && !mem_request_n) begin
               @(posedge clk);
               w--;
            end
            if (!mem_request_n) begin
               if (!transfer_direction) begin
                  host_data <= ~mem[ix];
                  host_par <= ~^{~mem[ix], a != PROT_ADDR} ^ bad_par;
               end else if (a == PROT_ADDR && prot_sw && protect_override_n) begin
                  protect_violation_n <= 1'b0;
               end else begin
                  mem[ix] = bus;
               end
               parity_error_line_n <= !perr;
               mem_resume_n <= 1'b0;
               while (!mem_request_n) @(posedge clk);
               repeat (20) @(posedge clk);
            end
            // Released lines flip so a stale word reads as bad, except after a read of PROT_ADDR
            mem_resume_n <= 1'b1;
            protect_violation_n <= 1'b1;
            parity_error_line_n <= 1'b1;
            protect_state_line <= 1'b1;
            host_data <= ~host_data;
            host_par <= ~host_par;
         end
      end
   end
endmodule

// >>> testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PROT = 16'h8003;
   logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, res_ready = 1'b0;
   logic priority_request = 1'b0, ring_forward_in = 1'b1, ring_reverse_in = 1'b0;
   logic system_clear_n = 1'b1, boot_load_strobe_n = 1'b1, bank_mode_n = 1'b1;
   logic perr = 1'b0, bad_par = 1'b0, prot_sw = 1'b0, slow = 1'b0;
   logic cmd_ready, res_valid, boot_load_seen, two_bank_mode, channel_cleared;
   logic mem_data_oe, parity_out, parity_oe, mem_request_n, transfer_direction;
   logic protect_override_n, priority_hold_n, ring_forward_out, ring_reverse_out;
   logic mem_resume_n, host_par, protect_state_line, parity_error_line_n;
   logic protect_violation_n;
   logic [15:0] mem_data_out, mem_address_lines, host_data;
   storage_access_pkg::cmd_t    cmd = '0;
   storage_access_pkg::result_t res;
   int error_cnt = 0, n_tests = 0, cyc_cnt = 0;
   // Whoever enables the line owns it; the host shows a flipping word when released
   wire logic [15:0] bus = mem_data_oe ? mem_data_out : host_data;
   wire logic        par = parity_oe ? parity_out : host_par;

   initial forever #5 clk = ~clk;

   storage_access_channel i_storage_access_channel (
      .clk, .reset, .cmd_valid, .cmd_ready, .cmd, .res_valid, .res_ready, .res,
      .priority_request, .boot_load_seen, .two_bank_mode, .channel_cleared,
      .mem_data_in(bus), .mem_data_out, .mem_data_oe, .parity_in(par), .parity_out,
      .parity_oe, .protect_state_line, .parity_error_line_n, .protect_violation_n,
      .mem_address_lines, .mem_request_n, .mem_resume_n, .transfer_direction,
      .protect_override_n, .priority_hold_n, .system_clear_n, .boot_load_strobe_n,
      .bank_mode_n, .ring_forward_in, .ring_reverse_in, .ring_forward_out, .ring_reverse_out
   );
   storage_host_model #(.PROT_ADDR(PROT)) i_storage_host_model (
      .clk, .mem_request_n, .mem_address_lines, .transfer_direction, .protect_override_n,
      .priority_hold_n, .bus, .perr, .bad_par, .prot_sw, .slow, .mem_resume_n, .host_data,
      .host_par, .protect_state_line, .parity_error_line_n, .protect_violation_n
   );

   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      n_tests++;
      if (e !== g) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Command held from a falling edge until the take edge has passed
   task automatic issue(input logic [15:0] a, d, input logic w, o);
      int k;
      k = 0;
      @(negedge clk);
      cmd = {a, d, w, o};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      if (k == 3000) chk("cmd_ready", 20'h00001, 20'h00000);
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask
   // Compare before the pop edge, while the head still stands
   task automatic take(input storage_access_pkg::result_t e);
      int k;
      k = 0;
      @(negedge clk);
      res_ready = 1'b1;
      while (res_valid !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      chk("res", e, res);
      @(negedge clk);
      res_ready = 1'b0;
   endtask
   task automatic cyc(input logic [15:0] a, d, input logic w, o, input logic [19:0] e);
      issue(a, d, w, o);
      take(e);
   endtask
   task automatic t_rw;
      cyc(16'h0005, 16'h1234, 1'b1, 1'b0, {16'h0000, 4'h8});
      cyc(16'h0005, 16'h0000, 1'b0, 1'b0, {16'h1234, 4'h0});
      priority_request = 1'b1;
      cyc(16'h800A, 16'hA55A, 1'b1, 1'b0, {16'h0000, 4'h8});
      cyc(16'h800A, 16'h0000, 1'b0, 1'b0, {16'hA55A, 4'h0});
      priority_request = 1'b0;
      $display("Test rw done");
   endtask
   task automatic t_prot;
      prot_sw = 1'b1;
      cyc(PROT, 16'h1111, 1'b1, 1'b0, {16'h0000, 4'hA});
      cyc(PROT, 16'h0000, 1'b0, 1'b0, {16'h0000, 4'h0});
      cyc(PROT, 16'h2222, 1'b1, 1'b1, {16'h0000, 4'h8});
      cyc(PROT, 16'h0000, 1'b0, 1'b0, {16'h2222, 4'h0});
      prot_sw = 1'b0;
      cyc(PROT, 16'h3333, 1'b1, 1'b0, {16'h0000, 4'h8});
      $display("Test protect done");
   endtask
   task automatic t_par;
      perr = 1'b1;
      cyc(16'h0001, 16'h0F0F, 1'b1, 1'b0, {16'h0000, 4'hC});
      perr = 1'b0;
      bad_par = 1'b1;
      cyc(16'h0001, 16'h0000, 1'b0, 1'b0, {16'h0F0F, 4'h1});
      bad_par = 1'b0;
      cyc(16'h0001, 16'h0000, 1'b0, 1'b0, {16'h0F0F, 4'h0});
      $display("Test parity done");
   endtask
   // Two results fill the buffer; the third waits inside, so cmd_ready stays low
   task automatic t_buf;
      for (int i = 0; i < 3; i++) begin
         cyc(16'h0010 + 16'(i), 16'hC0DE ^ 16'(i), 1'b1, 1'b0, {16'h0000, 4'h8});
      end
      for (int i = 0; i < 3; i++) issue(16'h0010 + 16'(i), 16'h0000, 1'b0, 1'b0);
      repeat (200) @(negedge clk);
      chk("stall", 20'h00002, {18'h0, res_valid, cmd_ready});
      for (int i = 0; i < 3; i++) take({16'hC0DE ^ 16'(i), 4'h0});
      $display("Test buffer done");
   endtask
   // Clear aborts a slow cycle; the channel must work again afterwards
   task automatic t_clear;
      int k;
      k = 0;
      slow = 1'b1;
      issue(16'h0005, 16'h0000, 1'b0, 1'b0);
      while (mem_request_n !== 1'b0 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk("request", 20'h00000, {19'h0, mem_request_n});
      // Scan moves on elsewhere; our stage must stay put while requesting
      ring_forward_in = 1'b0;
      repeat (5) @(negedge clk);
      chk("halt", 20'h00001, {19'h0, ring_forward_out});
      system_clear_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("clear", 20'h00003, {18'h0, channel_cleared, mem_request_n});
      system_clear_n = 1'b1;
      ring_forward_in = 1'b1;
      ring_reverse_in = 1'b1;
      boot_load_strobe_n = 1'b0;
      bank_mode_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("levels", 20'h00003, {18'h0, boot_load_seen, two_bank_mode});
      chk("ring", 20'h00006, {17'h0, ring_forward_out, ring_reverse_out, res_valid});
      ring_reverse_in = 1'b0;
      boot_load_strobe_n = 1'b1;
      bank_mode_n = 1'b1;
      slow = 1'b0;
      cyc(16'h0005, 16'h0000, 1'b0, 1'b0, {16'h1234, 4'h0});
      $display("Test clear done");
   endtask

   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      t_rw();
      t_prot();
      t_par();
      t_buf();
      t_clear();
      print_verdict();
   end
endmodule
